// ===== bench/afelpc_mod_src.sv
// Modulator bit stream source standing in for the converter side.
// Assumes the bench seeds $urandom before the first clock edge and that
// loop follows the analog loop switch of the design.
`timescale 1ns/1ps
`default_nettype none
module afelpc_mod_src (
  input wire logic clk,
  input wire logic loop,
  input wire logic tx_line,
  output logic tx_bit,
  output logic rx_bit
);
  initial begin
    tx_bit = 1'b0;
    rx_bit = 1'b1;
  end
  // New random bits every cycle so a stuck or swapped path shows up;
  // with the analog loop closed the transmit line returns as the receive
  // stream and the transmit stream stays at even density, near zero code
  always @(posedge clk) begin
    tx_bit <= loop ? !tx_bit : 1'($urandom);
    rx_bit <= loop ? tx_line : 1'($urandom);
  end
endmodule
`default_nettype wire

// ===== bench/afelpc_top_tb.sv
// Self-checking bench for the loopback and power control block.
// Assumes the design under hw/ and the bit stream source model.
`timescale 1ns/1ps
`default_nettype none
module afelpc_top_tb;
  logic clk_sys;
  logic srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack, tx_mod, rx_mod, tx_path, decim_in, ana_sw, tx_hiz, pwr_up;
  logic filt_en, ana_en, sport_en;
  logic [31:0] q[$];
  int n_fail = 0, checks_done = 0;

  afelpc_top afelpc_top_inst (.CLK_SYS(clk_sys), .SRST(srst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TX_MOD_BIT(tx_mod), .RX_MOD_BIT(rx_mod),
    .TX_PATH_BIT(tx_path), .DECIM_IN_BIT(decim_in), .ANA_LOOP_SW(ana_sw),
    .TX_HIZ(tx_hiz), .PWR_UP(pwr_up), .FILT_CLK_EN(filt_en), .ANA_CLK_EN(ana_en),
    .SPORT_CLK_EN(sport_en));
  afelpc_mod_src afelpc_mod_src_inst (.clk(clk_sys), .loop(ana_sw), .tx_line(tx_path),
    .tx_bit(tx_mod), .rx_bit(rx_mod));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One classic cycle; a read leaves its expected data for the monitor
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] e);
    int t;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h0, d};
    if (!w) q.push_back({24'h0, e});
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) chk(dat_o, q.pop_front());
  end

  task automatic clocks(input logic en);
    int f, a, s, i;
    f = 0;
    a = 0;
    s = 0;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      f += filt_en;
      a += ana_en;
      s += sport_en;
    end
    chk(f, en ? 4 : 0);
    chk(a, en ? 8 : 0);
    chk(s, 2);
    chk(pwr_up, en);
  endtask

  // Loop bits lb are {digital, analog, internal}
  task automatic streams(input logic [2:0] lb, input logic en);
    logic pt, pr;
    logic [7:0] v;
    int i;
    v = {1'($urandom), lb, 4'($urandom)};
    wb(1'b1, 8'h04, v, 8'h00);
    wb(1'b0, 8'h04, 8'h00, v);
    for (i = 0; i < 12; i++) begin
      pt = tx_mod;
      pr = rx_mod;
      @(posedge clk_sys);
      chk(tx_path, !en ? 1'b0 : lb[0] ? pr : pt);
      chk(decim_in, !en ? 1'b0 : lb[2] ? pt : pr);
      chk(ana_sw, lb[1]);
    end
    wb(1'b0, 8'h08, 8'h00, {4'h0, lb[1], lb[2], lb[0], en});
  endtask

  initial begin
    logic [7:0] r;
    int i;
    void'($urandom(32'h21F02CE0));
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(tx_hiz, 1'b1);
    chk(pwr_up, 1'b0);
    wb(1'b0, 8'h00, 8'h00, 8'h08);
    wb(1'b0, 8'h04, 8'h00, 8'h00);
    wb(1'b0, 8'h0C, 8'h00, 8'h00);
    wb(1'b0, 8'h40, 8'h00, 8'h00);
    clocks(1'b0);
    streams(3'h7, 1'b0);
    r = 8'($urandom) & 8'h7F;
    wb(1'b1, 8'h00, r, 8'h00);
    wb(1'b0, 8'h00, 8'h00, r & 8'h3F);
    chk(tx_hiz, 1'b1);
    wb(1'b1, 8'h00, 8'h80, 8'h00);
    chk(tx_hiz, 1'b0);
    clocks(1'b1);
    for (i = 0; i < 8; i++) streams(3'(i), 1'b1);
    wb(1'b1, 8'h00, 8'h00, 8'h00);
    clocks(1'b0);
    chk(tx_hiz, 1'b1);
    stop_test();
  end

  initial begin
    #200us;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire

// ===== hw/afelpc_div.sv
// Clock enable divider: one-cycle pulse every DIV cycles while run is high.
// Assumes a single system clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module afelpc_div #(
  parameter logic [7:0] DIV = 8'h02
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  output logic tick
);
  logic [7:0] cnt;

  // Stopped divider restarts from zero so the first pulse is a full period late
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cnt <= 8'h00;
    end else if (cnt == DIV - 8'h01) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (cnt == DIV - 8'h01);
    end
  end
endmodule
`default_nettype wire

// ===== hw/afelpc_params.svh
// Register map, field positions, reset values and divider counts of the
// loopback and power control block.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
`ifndef AFELPC_PARAMS_SVH
`define AFELPC_PARAMS_SVH

// Register indexes; byte address is four times the index
`define AFELPC_IDX_CTRL1 4'h0
`define AFELPC_IDX_SECOND 4'h1
`define AFELPC_IDX_STATUS 4'h2

// First control register fields
`define AFELPC_FE_EN_BIT 7
`define AFELPC_TXDIS_BIT 3
`define AFELPC_CTRL1_RST 8'h08
`define AFELPC_CTRL1_WMASK 8'hBF

// Second control register fields
`define AFELPC_INT_LB_BIT 4
`define AFELPC_ANA_LB_BIT 5
`define AFELPC_DIG_LB_BIT 6
`define AFELPC_SECOND_RST 8'h00

// Status register fields
`define AFELPC_ST_PWR_BIT 0
`define AFELPC_ST_TXLOOP_BIT 1
`define AFELPC_ST_DECLOOP_BIT 2
`define AFELPC_ST_ANASW_BIT 3

// Clock enable divisors, in system clock cycles
`define AFELPC_SPORT_DIV 8'h08
`define AFELPC_FILT_DIV 8'h04
`define AFELPC_ANA_DIV 8'h02

`endif

// ===== hw/afelpc_pkg.sv
// Types shared by the loopback and power control block.
// Assumes the constants header is included by the design files.
`default_nettype none
package afelpc_pkg;
  typedef enum logic {
    AFELPC_PWR_DOWN,
    AFELPC_PWR_UP
  } afelpc_pwr_t;
  typedef logic [7:0] afelpc_reg_t;
endpackage
`default_nettype wire

// ===== hw/afelpc_top.sv
// Loopback path selection and power control of the analog front end.
// Assumes a classic Wishbone master and modulator bit streams on CLK_SYS.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`include "afelpc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module afelpc_top (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic TX_MOD_BIT,
  input wire logic RX_MOD_BIT,
  output logic TX_PATH_BIT,
  output logic DECIM_IN_BIT,
  output logic ANA_LOOP_SW,
  output logic TX_HIZ,
  output logic PWR_UP,
  output logic FILT_CLK_EN,
  output logic ANA_CLK_EN,
  output logic SPORT_CLK_EN
);
  afelpc_pkg::afelpc_reg_t first_control_reg;
  afelpc_pkg::afelpc_reg_t second_control_reg;
  afelpc_pkg::afelpc_reg_t status_word;
  afelpc_pkg::afelpc_pwr_t pwr_state;
  afelpc_pkg::afelpc_pwr_t next_pwr_state;
  logic front_end_enable;
  logic internal_loopback_en;
  logic analog_loopback_en;
  logic digital_loopback_en;
  logic tx_disable;
  logic bus_req;
  logic bus_take;
  logic [3:0] reg_idx;
  logic addr_high_zero;
  afelpc_pkg::afelpc_reg_t next_rdata;

  assign front_end_enable = first_control_reg[`AFELPC_FE_EN_BIT];
  assign tx_disable = first_control_reg[`AFELPC_TXDIS_BIT];
  assign internal_loopback_en = second_control_reg[`AFELPC_INT_LB_BIT];
  assign analog_loopback_en = second_control_reg[`AFELPC_ANA_LB_BIT];
  assign digital_loopback_en = second_control_reg[`AFELPC_DIG_LB_BIT];

  // Bus decode; a request is answered one cycle after it is seen
  assign bus_req = WB_CYC_I && WB_STB_I;
  assign bus_take = bus_req && !WB_ACK_O;
  assign reg_idx = WB_ADR_I[5:2];
  assign addr_high_zero = (WB_ADR_I[7:6] == 2'b00);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_take;
    end
  end

  // Register writes do not depend on the power state
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      first_control_reg <= `AFELPC_CTRL1_RST;
    end else if (bus_take && WB_WE_I && WB_SEL_I[0] && addr_high_zero &&
        reg_idx == `AFELPC_IDX_CTRL1) begin
      first_control_reg <= WB_DAT_I[7:0] & `AFELPC_CTRL1_WMASK;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      second_control_reg <= `AFELPC_SECOND_RST;
    end else if (bus_take && WB_WE_I && WB_SEL_I[0] && addr_high_zero &&
        reg_idx == `AFELPC_IDX_SECOND) begin
      second_control_reg <= WB_DAT_I[7:0];
    end
  end

  always_comb begin
    status_word = 8'h00;
    status_word[`AFELPC_ST_PWR_BIT] = (pwr_state == afelpc_pkg::AFELPC_PWR_UP);
    status_word[`AFELPC_ST_TXLOOP_BIT] = internal_loopback_en;
    status_word[`AFELPC_ST_DECLOOP_BIT] = digital_loopback_en;
    status_word[`AFELPC_ST_ANASW_BIT] = ANA_LOOP_SW;
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    next_rdata = 8'h00;
    if (addr_high_zero) begin
      case (reg_idx)
        `AFELPC_IDX_CTRL1: next_rdata = first_control_reg;
        `AFELPC_IDX_SECOND: next_rdata = second_control_reg;
        `AFELPC_IDX_STATUS: next_rdata = status_word;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      WB_DAT_O <= 32'h00000000;
    end else if (bus_take && !WB_WE_I) begin
      WB_DAT_O <= {24'h000000, next_rdata};
    end
  end

  // Power state follows the enable bit
  always_comb begin
    case (pwr_state)
      afelpc_pkg::AFELPC_PWR_DOWN: begin
        next_pwr_state = front_end_enable ? afelpc_pkg::AFELPC_PWR_UP :
          afelpc_pkg::AFELPC_PWR_DOWN;
      end
      afelpc_pkg::AFELPC_PWR_UP: begin
        next_pwr_state = front_end_enable ? afelpc_pkg::AFELPC_PWR_UP :
          afelpc_pkg::AFELPC_PWR_DOWN;
      end
      default: next_pwr_state = afelpc_pkg::AFELPC_PWR_DOWN;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pwr_state <= afelpc_pkg::AFELPC_PWR_DOWN;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PWR_UP <= 1'b0;
    end else begin
      PWR_UP <= front_end_enable;
    end
  end

  // Transmit pins float while disabled or powered down
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      TX_HIZ <= 1'b1;
    end else begin
      TX_HIZ <= tx_disable || !front_end_enable;
    end
  end

  // Bit stream steering; streams are held low while the clocks are stopped
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      TX_PATH_BIT <= 1'b0;
    end else if (!front_end_enable) begin
      TX_PATH_BIT <= 1'b0;
    end else if (internal_loopback_en) begin
      TX_PATH_BIT <= RX_MOD_BIT;
    end else begin
      TX_PATH_BIT <= TX_MOD_BIT;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      DECIM_IN_BIT <= 1'b0;
    end else if (!front_end_enable) begin
      DECIM_IN_BIT <= 1'b0;
    end else if (digital_loopback_en) begin
      DECIM_IN_BIT <= TX_MOD_BIT;
    end else begin
      DECIM_IN_BIT <= RX_MOD_BIT;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ANA_LOOP_SW <= 1'b0;
    end else begin
      ANA_LOOP_SW <= analog_loopback_en;
    end
  end

  // Clock enables: filters and analog gated, serial port free running
  afelpc_div #(
    .DIV(`AFELPC_FILT_DIV)
  ) u_filt_div (
    .clk(CLK_SYS),
    .srst(SRST),
    .run(front_end_enable),
    .tick(FILT_CLK_EN)
  );

  afelpc_div #(
    .DIV(`AFELPC_ANA_DIV)
  ) u_ana_div (
    .clk(CLK_SYS),
    .srst(SRST),
    .run(front_end_enable),
    .tick(ANA_CLK_EN)
  );

  afelpc_div #(
    .DIV(`AFELPC_SPORT_DIV)
  ) u_sport_div (
    .clk(CLK_SYS),
    .srst(SRST),
    .run(1'b1),
    .tick(SPORT_CLK_EN)
  );

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  sequence s_second_write;
    bus_take && WB_WE_I && WB_SEL_I[0] && addr_high_zero &&
      reg_idx == `AFELPC_IDX_SECOND;
  endsequence

  sequence s_fe_short;
    $rose(front_end_enable) ##0 front_end_enable [*2];
  endsequence

  sequence s_fe_wakeup;
    $rose(front_end_enable) ##0 front_end_enable [*4];
  endsequence

  sequence s_sport_quiet;
    !SPORT_CLK_EN [*8];
  endsequence

  a_int_loop_path: assert property (
    front_end_enable && internal_loopback_en |=> TX_PATH_BIT == $past(RX_MOD_BIT))
    else $error("transmit path did not take the receive stream");

  a_tx_normal_path: assert property (
    front_end_enable && !internal_loopback_en |=> TX_PATH_BIT == $past(TX_MOD_BIT))
    else $error("transmit path did not take the transmit stream");

  a_ana_loop_switch: assert property (
    $changed(analog_loopback_en) |=> ANA_LOOP_SW == $past(analog_loopback_en)
      ##1 ANA_LOOP_SW == $past(ANA_LOOP_SW) || $changed(analog_loopback_en))
    else $error("analog loop switch does not follow its bit");

  a_dig_loop_path: assert property (
    front_end_enable && digital_loopback_en |=> DECIM_IN_BIT == $past(TX_MOD_BIT))
    else $error("decimator input did not take the transmit stream");

  a_pd_clocks_off: assert property (
    !front_end_enable |=> !FILT_CLK_EN && !ANA_CLK_EN && TX_HIZ && !PWR_UP)
    else $error("clock enable active while powered down");

  a_fe_filter_start: assert property (
    s_fe_wakeup |=> FILT_CLK_EN && PWR_UP)
    else $error("filter clock did not start after enable");

  a_sport_running: assert property (
    s_sport_quiet |=> SPORT_CLK_EN)
    else $error("serial port clock enable stalled");

  a_second_write_pd: assert property (
    s_second_write |=> second_control_reg == $past(WB_DAT_I[7:0]) ##0 WB_ACK_O)
    else $error("control write lost or not acknowledged");

  a_reset_clears: assert property (
    $past(SRST) |-> !internal_loopback_en && !analog_loopback_en &&
      !digital_loopback_en && !front_end_enable && !ANA_LOOP_SW)
    else $error("loopback or enable bit set after reset");

  a_ack_single: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge held longer than one cycle");

  a_dec_normal_path: assert property (
    front_end_enable && !digital_loopback_en |=> DECIM_IN_BIT == $past(RX_MOD_BIT))
    else $error("decimator input did not take the receive stream");

  a_pd_streams_low: assert property (
    !front_end_enable |=> !TX_PATH_BIT && !DECIM_IN_BIT)
    else $error("bit stream active while powered down");

  a_ana_clk_start: assert property (
    s_fe_short |=> ANA_CLK_EN)
    else $error("analog clock did not start after enable");

  a_read_upper_zero: assert property (
    WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("read data has bits above the register");

  a_bus_answers: assert property (
    bus_take |=> WB_ACK_O)
    else $error("bus request not acknowledged");
endmodule
`default_nettype wire
